// >>> rcms_host_model.sv
// Master clock source standing in for the board oscillator
`timescale 1ns/1ns
`default_nettype none
module rcms_host_model #(parameter int HALF_NS = 244)
(
   // Control: 0 held low, 1 held high, 2 free-running
   input wire logic [1:0] sel,
   // Clock pin
   output var logic mclk
);
   logic osc = 1'b0;
   // Runs regardless of line data; the bench gates only the mclk pin, through sel
   always #(HALF_NS) osc = ~osc;
   assign mclk = sel[1] ? osc : sel[0];
endmodule
`default_nettype wire

// >>> rcms_mclk_if.sv
// Master clock status carried from the clock monitor to the control logic
`timescale 1ns/1ns
`default_nettype none
interface rcms_mclk_if;
   logic tick;
   logic present;
   logic level;
   logic static_hi;
   logic static_lo;
   modport mon (output tick, output present, output level,
                output static_hi, output static_lo);
   modport ctl (input tick, input present, input level,
                input static_hi, input static_lo);
endinterface
`default_nettype wire

// >>> rcms_mclk_mon.sv
// Master clock activity monitor: synchroniser, edge ticks, static detection
`timescale 1ns/1ns
`default_nettype none
module rcms_mclk_mon
   import rcms_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Master clock pin
   input wire logic mclk,
   // Status to the control logic
   rcms_mclk_if.mon st
);
   logic [1:0] sync_ff;
   logic prev_ff;
   logic present_ff;
   logic [RCMS_TMO_W-1:0] idle_cnt_ff;
   logic [RCMS_TMO_W-1:0] nxt_idle_cnt;
   logic nxt_present;
   wire mclk_s = sync_ff[1];
   wire edge_any = mclk_s ^ prev_ff;
   wire cnt_done = (idle_cnt_ff == RCMS_TMO_LAST);

   // Any edge restarts the watchdog; a full timeout means the clock stopped
   assign nxt_idle_cnt = edge_any ? RCMS_TMO_RST :
                         cnt_done ? idle_cnt_ff : idle_cnt_ff + 1'b1;
   assign nxt_present = edge_any ? 1'b1 : (cnt_done ? 1'b0 : present_ff);

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         sync_ff <= RCMS_SYNC_RST;
         prev_ff <= 1'b0;
         idle_cnt_ff <= RCMS_TMO_RST;
         present_ff <= 1'b0;
      end
      else
      begin
         sync_ff <= {sync_ff[0], mclk};
         prev_ff <= mclk_s;
         idle_cnt_ff <= nxt_idle_cnt;
         present_ff <= nxt_present;
      end
   end

   assign st.tick = mclk_s & ~prev_ff;
   assign st.present = present_ff;
   assign st.level = mclk_s;
   assign st.static_hi = ~present_ff & prev_ff;
   assign st.static_lo = ~present_ff & ~prev_ff;
endmodule
`default_nettype wire

// >>> rcms_pkg.sv
// Constants and types shared by the reference clock and mode select block
`default_nettype none
package rcms_pkg;
   // Control modes chosen by the three-level mode input
   typedef enum logic [1:0] {
      RCMS_MODE_HW,
      RCMS_MODE_PAR,
      RCMS_MODE_SER
   } rcms_mode_t;

   // Wait-state handshake states
   typedef enum logic [1:0] {
      RCMS_WS_IDLE,
      RCMS_WS_WAIT,
      RCMS_WS_ACK
   } rcms_ws_t;

   // System clock period
   localparam int RCMS_CLK_PERIOD_NS = 4;
   // Slowest master clock is 1.544 MHz, about 648 ns a period
   localparam int RCMS_MCLK_TIMEOUT_NS = 2000;
   // Longest wait for an edge, rounded up to whole cycles
   localparam int RCMS_MCLK_TIMEOUT_CYC =
      (RCMS_MCLK_TIMEOUT_NS + RCMS_CLK_PERIOD_NS - 1) / RCMS_CLK_PERIOD_NS;
   localparam int RCMS_TMO_W = 10;
   localparam logic [RCMS_TMO_W-1:0] RCMS_TMO_LAST =
      RCMS_TMO_W'(RCMS_MCLK_TIMEOUT_CYC - 1);

   // Master clock edges inserted as wait states on a parallel access
   localparam int RCMS_WAIT_TICKS = 2;
   localparam logic [2:0] RCMS_WAIT_LAST = 3'(RCMS_WAIT_TICKS - 1);

   // Cycles after reset release before the mode straps are latched
   localparam logic [1:0] RCMS_MODE_CAP_CYC = 2'h3;

   // Reset values
   localparam logic [RCMS_TMO_W-1:0] RCMS_TMO_RST = '0;
   localparam logic [1:0] RCMS_SYNC_RST = 2'h0;
endpackage
`default_nettype wire

// >>> rcms_top.sv
// Reference clock use and control mode selection for the quad transceiver
`timescale 1ns/1ns
`default_nettype none
module rcms_top
   import rcms_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Master reference clock pin
   input wire logic mclk,
   // Mode input comparators: above two thirds and below one third of Vcc
   input wire logic mode_above_hi,
   input wire logic mode_below_lo,
   // Top address pin
   input wire logic addr_bit_four,
   // Receive path from the line receiver
   input wire logic rx_clk_in,
   input wire logic rx_pos_in,
   input wire logic rx_neg_in,
   input wire logic rx_los,
   // Receive pins, output enables low while driven
   output logic rx_clk_out,
   output logic rx_positive_data,
   output logic rx_negative_data,
   output logic rx_oe_n,
   // Receive path control
   output logic rx_power_down,
   output logic cdr_enable,
   output logic ja_ref_tick,
   output logic cdr_ref_tick,
   // All-ones transmit timing
   input wire logic taos_req,
   output logic taos_tick,
   // Parallel host wait state
   input wire logic par_strobe,
   output logic rdy_ack,
   output logic rdy_ack_oe_n,
   // Serial host port
   input wire logic serial_cfg_in,
   input wire logic ser_data_int,
   output logic ser_data_sync,
   output logic serial_cfg_out,
   output logic serial_cfg_out_oe_n,
   // Mode outputs to the rest of the device
   output logic par_if_enable,
   output logic ser_if_enable,
   output logic hw_pins_enable,
   output logic reg_addr_msb
);
   rcms_mclk_if mst ();

   rcms_mclk_mon u_mon (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .mclk(mclk),
      .st(mst)
   );

   // Pin synchronisers
   logic [1:0] mhi_sync_ff;
   logic [1:0] mlo_sync_ff;
   logic [1:0] a4_sync_ff;
   logic [1:0] sdi_sync_ff;

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mhi_sync_ff <= RCMS_SYNC_RST;
         mlo_sync_ff <= RCMS_SYNC_RST;
         a4_sync_ff <= RCMS_SYNC_RST;
         sdi_sync_ff <= RCMS_SYNC_RST;
      end
      else
      begin
         mhi_sync_ff <= {mhi_sync_ff[0], mode_above_hi};
         mlo_sync_ff <= {mlo_sync_ff[0], mode_below_lo};
         a4_sync_ff <= {a4_sync_ff[0], addr_bit_four};
         sdi_sync_ff <= {sdi_sync_ff[0], serial_cfg_in};
      end
   end

   // Mode decode; mid level is neither comparator asserted
   wire rcms_mode_t mode_dec = mhi_sync_ff[1] ? RCMS_MODE_PAR :
                               mlo_sync_ff[1] ? RCMS_MODE_HW :
                               RCMS_MODE_SER;

   // Mode is a strap: latched once after reset, hardware mode until then
   rcms_mode_t mode_ff;
   logic [1:0] cap_cnt_ff;
   wire cap_now = (cap_cnt_ff == RCMS_MODE_CAP_CYC - 2'h1);
   wire [1:0] nxt_cap_cnt = (cap_cnt_ff == RCMS_MODE_CAP_CYC) ?
                            cap_cnt_ff : cap_cnt_ff + 2'h1;
   wire rcms_mode_t nxt_mode = cap_now ? mode_dec : mode_ff;

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cap_cnt_ff <= RCMS_SYNC_RST;
         mode_ff <= RCMS_MODE_HW;
      end
      else
      begin
         cap_cnt_ff <= nxt_cap_cnt;
         mode_ff <= nxt_mode;
      end
   end

   wire mode_par = (mode_ff == RCMS_MODE_PAR);
   wire mode_ser = (mode_ff == RCMS_MODE_SER);
   wire mode_host = mode_par | mode_ser;

   assign par_if_enable = mode_par;
   assign hw_pins_enable = ~mode_host;
   assign ser_if_enable = mode_ser;
   // Pin is grounded in hardware mode, but gate it anyway
   assign reg_addr_msb = mode_host & a4_sync_ff[1];

   // Receive path control by master clock state
   assign cdr_enable = mst.present;
   assign rx_power_down = mst.static_lo;
   assign cdr_ref_tick = mst.tick;
   assign ja_ref_tick = mst.tick;
   assign taos_tick = taos_req & mst.tick;

   // During loss of signal the clock pin follows the master clock while it is present, otherwise rx_clk_in
   wire rclk_src = (rx_los & mst.present) ? mst.level : rx_clk_in;

   logic rclk_ff;
   logic rx_positive_data_ff;
   logic rx_negative_data_ff;
   logic rx_oe_n_ff;
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rclk_ff <= 1'b0;
         rx_positive_data_ff <= 1'b0;
         rx_negative_data_ff <= 1'b0;
         rx_oe_n_ff <= 1'b1;
      end
      else
      begin
         rclk_ff <= rclk_src & ~mst.static_lo;
         rx_positive_data_ff <= rx_pos_in & ~mst.static_lo;
         rx_negative_data_ff <= rx_neg_in & ~mst.static_lo;
         rx_oe_n_ff <= mst.static_lo;
      end
   end
   assign rx_clk_out = rclk_ff;
   assign rx_positive_data = rx_positive_data_ff;
   assign rx_negative_data = rx_negative_data_ff;
   assign rx_oe_n = rx_oe_n_ff;

   // Wait-state generator counted in master clock edges
   rcms_ws_t ws_ff;
   rcms_ws_t nxt_ws;
   logic [2:0] ws_cnt_ff;
   logic [2:0] nxt_ws_cnt;
   wire ws_ok = mode_par & mst.present;

   always_comb
   begin
      nxt_ws = ws_ff;
      nxt_ws_cnt = ws_cnt_ff;
      case (ws_ff)
         RCMS_WS_IDLE:
         begin
            nxt_ws_cnt = 3'h0;
            if (par_strobe && ws_ok)
               nxt_ws = RCMS_WS_WAIT;
         end
         RCMS_WS_WAIT:
         begin
            if (!par_strobe || !ws_ok)
               nxt_ws = RCMS_WS_IDLE;
            else if (mst.tick)
            begin
               if (ws_cnt_ff == RCMS_WAIT_LAST)
                  nxt_ws = RCMS_WS_ACK;
               else
                  nxt_ws_cnt = ws_cnt_ff + 3'h1;
            end
         end
         RCMS_WS_ACK:
         begin
            if (!par_strobe || !ws_ok)
               nxt_ws = RCMS_WS_IDLE;
         end
         default:
            nxt_ws = RCMS_WS_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         ws_ff <= RCMS_WS_IDLE;
         ws_cnt_ff <= 3'h0;
      end
      else
      begin
         ws_ff <= nxt_ws;
         ws_cnt_ff <= nxt_ws_cnt;
      end
   end

   // Handshake pin floats whenever no master clock is there to time it
   assign rdy_ack = (ws_ff == RCMS_WS_ACK);
   assign rdy_ack_oe_n = ~(ws_ok & par_strobe & (ws_ff != RCMS_WS_IDLE));

   // Serial port data, driven only in serial host mode
   logic sdo_ff;
   always_ff @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
         sdo_ff <= 1'b0;
      else
         sdo_ff <= ser_data_int & mode_ser;
   end
   assign serial_cfg_out = sdo_ff;
   assign serial_cfg_out_oe_n = ~mode_ser;
   assign ser_data_sync = sdi_sync_ff[1] & mode_ser;
endmodule
`default_nettype wire

// >>> rcms_top_assertions.sv
// Port-level checks for the reference clock and mode block
`timescale 1ns/1ns
`default_nettype none
module rcms_top_assertions
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Watched ports
   input wire logic par_strobe,
   input wire logic taos_req,
   input wire logic ser_data_int,
   input wire logic rx_clk_out,
   input wire logic rx_positive_data,
   input wire logic rx_negative_data,
   input wire logic rx_oe_n,
   input wire logic rx_power_down,
   input wire logic cdr_enable,
   input wire logic ja_ref_tick,
   input wire logic cdr_ref_tick,
   input wire logic taos_tick,
   input wire logic rdy_ack,
   input wire logic rdy_ack_oe_n,
   input wire logic serial_cfg_out,
   input wire logic serial_cfg_out_oe_n,
   input wire logic par_if_enable,
   input wire logic ser_if_enable,
   input wire logic hw_pins_enable,
   input wire logic reg_addr_msb
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   sequence s_ack_drop;
      rdy_ack && !par_strobe;
   endsequence
   AST_ACK_DROP: assert property (s_ack_drop |=> !rdy_ack)
      else $error("ack held after strobe fell");
   AST_ACK_NOCLK: assert property (!cdr_enable |=> !rdy_ack)
      else $error("ack without master clock");
   // Pin floats as soon as the strobe drops, while ack still stands
   AST_ACK_OE: assert property (rdy_ack |-> par_if_enable &&
      (rdy_ack_oe_n == !(par_strobe && cdr_enable)))
      else $error("ack pin not driven or wrong mode");
   AST_NOCLK_FLOAT: assert property (!cdr_enable |-> rdy_ack_oe_n)
      else $error("handshake pin driven without master clock");
   AST_PWR_FLOAT: assert property (rx_power_down |=> rx_oe_n
      && !rx_positive_data && !rx_negative_data && !rx_clk_out)
      else $error("receive pins active in power down");
   AST_CDR_PWR: assert property (cdr_enable |-> !rx_power_down)
      else $error("recovery on while powered down");
   AST_TICK_PAIR: assert property (ja_ref_tick |->
      cdr_ref_tick ##1 !ja_ref_tick)
      else $error("reference ticks mismatched");
   AST_TAOS: assert property (taos_tick == (taos_req && ja_ref_tick))
      else $error("all-ones tick wrong");
   AST_MODE_ONE: assert property ($onehot({par_if_enable,
      ser_if_enable, hw_pins_enable}))
      else $error("mode not one-hot");
   AST_HW_ADDR: assert property (hw_pins_enable |-> !reg_addr_msb)
      else $error("address bit used in hardware mode");
   AST_SER_OE: assert property (ser_if_enable != serial_cfg_out_oe_n)
      else $error("serial out enable wrong");
   AST_SER_OUT: assert property (ser_if_enable && $past(ser_if_enable)
      |-> serial_cfg_out == $past(ser_data_int))
      else $error("serial out data wrong");
endmodule
bind rcms_top rcms_top_assertions u_chk (.*);
`default_nettype wire

// >>> test_ref_clock_and_mode_select.sv
// Self-checking bench for the reference clock and mode block
`timescale 1ns/1ns
`default_nettype none
module test_ref_clock_and_mode_select;
   import rcms_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic [1:0] sel = 2'h2;
   logic mode_above_hi = 1'b0, mode_below_lo = 1'b1, addr_bit_four = 1'b1;
   logic rx_clk_in = 1'b0, rx_pos_in = 1'b1, rx_neg_in = 1'b0, rx_los = 1'b0;
   logic taos_req = 1'b0, par_strobe = 1'b0;
   logic serial_cfg_in = 1'b1, ser_data_int = 1'b1;
   wire mclk, rx_clk_out, rx_positive_data, rx_negative_data, rx_oe_n;
   wire rx_power_down, cdr_enable, ja_ref_tick, cdr_ref_tick, taos_tick;
   wire rdy_ack, rdy_ack_oe_n, ser_data_sync, serial_cfg_out;
   wire serial_cfg_out_oe_n, par_if_enable, ser_if_enable;
   wire hw_pins_enable, reg_addr_msb;
   wire [3:0] mode_vec = {par_if_enable, ser_if_enable, hw_pins_enable,
      reg_addr_msb};
   wire [3:0] rx_vec = {rx_power_down, rx_oe_n, cdr_enable, rx_positive_data};
   wire [3:0] ack_vec = {2'h0, rdy_ack, rdy_ack_oe_n};
   wire [3:0] ser_vec = {1'b0, serial_cfg_out, ser_data_sync,
      serial_cfg_out_oe_n};
   int n_mismatch = 0;
   int check_count = 0;
   always #2 clk_sys = ~clk_sys;
   rcms_host_model host (.sel(sel), .mclk(mclk));
   rcms_top uut (.*);
   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task chk(input logic [3:0] got, input logic [3:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task start(input logic hi, input logic lo);
      reset_n = 1'b0;
      mode_above_hi = hi;
      mode_below_lo = lo;
      addr_bit_four = hi | ~lo;
      cyc(8);
      reset_n = 1'b1;
      cyc(700);
   endtask
   task automatic t_modes;
      logic [3:0] en [3] = '{4'h2, 4'h9, 4'h5};
      logic [3:0] sr [3] = '{4'h1, 4'h1, 4'h6};
      for (int m = 0; m < 3; m++)
      begin
         start(m == 1, m == 0);
         chk(mode_vec, en[m]);
         chk(ser_vec, sr[m]);
         // Strap change after the latch must be ignored
         mode_above_hi = ~mode_above_hi;
         // Low data and address must show through only in their mode
         ser_data_int = 1'b0;
         serial_cfg_in = 1'b0;
         addr_bit_four = 1'b0;
         cyc(10);
         chk(mode_vec, en[m] & 4'hE);
         chk(ser_vec, sr[m] & 4'h1);
         ser_data_int = 1'b1;
         serial_cfg_in = 1'b1;
      end
   endtask
   task automatic t_los;
      int nr = 0;
      int nt = 0;
      logic last;
      rx_los = 1'b1;
      rx_neg_in = 1'b1;
      cyc(2);
      last = rx_clk_out;
      repeat (500)
      begin
         cyc(1);
         nr += (rx_clk_out && !last);
         nt += cdr_ref_tick;
         last = rx_clk_out;
      end
      // Clock pin follows the master clock during loss of signal
      chk({rx_negative_data, rx_oe_n, nr > 3, nt > 3}, 4'hB);
      rx_los = 1'b0;
      rx_neg_in = 1'b0;
      cyc(2);
      chk({rx_negative_data, rx_clk_out, rx_vec[3:2]}, 4'h0);
   endtask
   task automatic t_ticks;
      int ja = 0;
      int tt = 0;
      taos_req = 1'b1;
      repeat (500)
      begin
         cyc(1);
         ja += ja_ref_tick;
         tt += taos_tick;
      end
      chk({cdr_enable, rx_power_down, ja == tt, ja > 3}, 4'hB);
      taos_req = 1'b0;
   endtask
   task automatic t_wait;
      int i;
      par_strobe = 1'b1;
      cyc(2);
      chk(ack_vec, 4'h0);
      for (i = 0; i < 400 && rdy_ack !== 1'b1; i++)
         cyc(1);
      chk(ack_vec, 4'h2);
      // Two rising master clock edges cannot fit in under 100 cycles
      chk({3'h0, i > 100}, 4'h1);
      par_strobe = 1'b0;
      cyc(1);
      chk(ack_vec, 4'h1);
   endtask
   task t_lo;
      sel = 2'h0;
      cyc(600);
      chk(rx_vec, 4'hC);
      par_strobe = 1'b1;
      cyc(300);
      chk(ack_vec, 4'h1);
      par_strobe = 1'b0;
   endtask
   task t_hi;
      sel = 2'h1;
      cyc(600);
      chk(rx_vec, 4'h1);
      sel = 2'h2;
      cyc(300);
      chk({3'h0, cdr_enable}, 4'h1);
   endtask
   task tally_and_finish;
      if (n_mismatch == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      t_modes();
      start(1'b1, 1'b0);
      t_ticks();
      t_wait();
      t_los();
      t_lo();
      t_hi();
      tally_and_finish();
   end
   initial
   begin
      #100000;
      n_mismatch++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
